// ==== shared/probe_latch_pkg.sv ====
// Shared constants, object indices and carrier types of the touch probe position latch
package probe_latch_pkg;

   // Clock rate and capture resolutions
   localparam int CLK_HZ = 10_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int COARSE_RES_US = 55;
   localparam int FINE_RES_US = 2;
   // A resolution is a longest sampling interval, so it rounds down, never below one cycle
   localparam int COARSE_RES_CYC = (COARSE_RES_US * CLK_MHZ < 1) ? 1 : COARSE_RES_US * CLK_MHZ;
   localparam int FINE_RES_CYC = (FINE_RES_US * CLK_MHZ < 1) ? 1 : FINE_RES_US * CLK_MHZ;

   // Object indices
   localparam logic [15:0] IDX_CONTROL = 16'h60B8;
   localparam logic [15:0] IDX_STATUS = 16'h60B9;
   localparam logic [15:0] IDX_P1_RISE = 16'h60BA;
   localparam logic [15:0] IDX_P1_FALL = 16'h60BB;
   localparam logic [15:0] IDX_P2_RISE = 16'h60BC;
   localparam logic [15:0] IDX_P2_FALL = 16'h60BD;

   // Reset values
   localparam logic [7:0] CTRL_CH_RESET = 8'h00;
   localparam logic [31:0] POS_RESET = 32'h00000000;

   // Channel field layout inside the 16-bit words
   localparam int CH_BITS = 8;
   localparam int CH2_BASE = 8;
   // Defined control bits per channel: enable, mode, source, rising, falling
   localparam logic [7:0] CTRL_DEFINED_MASK = 8'h37;

   // Per-channel control byte, bit 0 at the bottom
   typedef struct packed {
      logic [1:0] rsv_hi;      // Bits 7:6
      logic sample_fall;       // Bit 5
      logic sample_rise;       // Bit 4
      logic rsv_lo;            // Bit 3
      logic src_zero_pt;       // Bit 2, unsupported source
      logic continuous;        // Bit 1
      logic enable;            // Bit 0
   } probe_ctrl_t;

   // Per-channel status byte
   typedef struct packed {
      logic [4:0] rsv;         // Bits 7:3
      logic fall_stored;       // Bit 2
      logic rise_stored;       // Bit 1
      logic enabled;           // Bit 0
   } probe_stat_t;

   // Object access request and answer
   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] index;
      logic [31:0] wdata;
   } obj_req_t;

   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
   } obj_rsp_t;

endpackage : probe_latch_pkg

// ==== design/probe_edge_sampler.sv ====
// Synchroniser and timed edge sampler for one probe input
`timescale 1ns/10ps
module probe_edge_sampler
   import probe_latch_pkg::*;
#(
   parameter int COARSE_CYC = COARSE_RES_CYC,
   parameter int FINE_CYC = FINE_RES_CYC
) (
   input wire logic sys_clk,        // System clock
   input wire logic nrst,           // Asynchronous reset, active low
   input wire logic pin,            // Raw probe pin
   input wire logic fine_rise_sel,  // Sample rising edges on the fine grid
   output logic rise_evt,           // One-cycle rising edge pulse
   output logic fall_evt            // One-cycle falling edge pulse
);

   localparam int CW = (COARSE_CYC > 1) ? $clog2(COARSE_CYC) : 1;
   localparam int FW = (FINE_CYC > 1) ? $clog2(FINE_CYC) : 1;

   logic [1:0] sync_reg;
   logic level;
   logic [CW-1:0] coarse_cnt_reg;
   logic [FW-1:0] fine_cnt_reg;
   logic coarse_tick;
   logic fine_tick;
   logic rise_tick;
   logic rise_lvl_reg;
   logic fall_lvl_reg;

   // Two-stage synchroniser; only the second stage is looked at
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sync_reg <= 2'h0;
      end else begin
         sync_reg <= {sync_reg[0], pin};
      end
   end
   assign level = sync_reg[1];

   // Coarse sampling grid
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         coarse_cnt_reg <= '0;
      end else if (coarse_tick) begin
         coarse_cnt_reg <= '0;
      end else begin
         coarse_cnt_reg <= coarse_cnt_reg + CW'(1);
      end
   end

   // Fine sampling grid
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fine_cnt_reg <= '0;
      end else if (fine_tick) begin
         fine_cnt_reg <= '0;
      end else begin
         fine_cnt_reg <= fine_cnt_reg + FW'(1);
      end
   end

   assign coarse_tick = (coarse_cnt_reg == CW'(COARSE_CYC - 1));
   assign fine_tick = (fine_cnt_reg == FW'(FINE_CYC - 1));
   // Only the rising path may run fine; falling keeps the coarse grid
   assign rise_tick = fine_rise_sel ? fine_tick : coarse_tick; // RULE18

   // Separate level memories so each edge sees its own grid
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rise_lvl_reg <= 1'b0;
         fall_lvl_reg <= 1'b0;
      end else begin
         if (rise_tick) begin
            rise_lvl_reg <= level;
         end
         if (coarse_tick) begin
            fall_lvl_reg <= level;
         end
      end
   end

   // Edge pulses on the sampling grids
   assign rise_evt = rise_tick & level & ~rise_lvl_reg; // RULE17
   assign fall_evt = coarse_tick & ~level & fall_lvl_reg; // RULE17

   a_fall_coarse_grid: assert property (@(posedge sys_clk) disable iff (!nrst)
      fall_evt |-> coarse_tick && $past(coarse_tick, COARSE_CYC)) // RULE18
      else $error("falling edge reported off the coarse grid");

   a_coarse_tick_gap: assert property (@(posedge sys_clk) disable iff (!nrst)
      coarse_tick |=> (!coarse_tick) [*8]) // RULE17
      else $error("coarse sampling ticks too close together");

endmodule : probe_edge_sampler

// ==== design/touch_probe_position_latch.sv ====
// Two-channel touch probe position latch with indexed object access
//
// Functional notes
// RULE1: Control bits 0 and 8 enable or disable probe channels one and two.
// RULE2: Control bits 1 and 9 pick single (0) or continuous (1) triggering.
// RULE3: Control bits 2 and 10 pick trigger source; only the probe input works.
// RULE4: Control bits 4 and 12 start or stop rising edge sampling.
// RULE5: Control bits 5 and 13 start or stop falling edge sampling.
// RULE6: Reserved control bits are written zero and carry no meaning.
// RULE7: Status bits 0 and 8 follow the channel enable control bits.
// RULE8: Status bits 1 and 9 set once a rising edge position is latched.
// RULE9: Status bits 2 and 10 set once a falling edge position is latched.
// RULE10: Channel one rising edge captures position into its rising object and flags it.
// RULE11: Channel one falling edge captures position into its falling object and flags it.
// RULE12: Channel two latches rising and falling positions into its own objects.
// RULE13: Position objects are 32-bit read-only values reading zero after reset.
// RULE14: Clearing rising sample clears rising stored flag, keeps latched position.
// RULE15: Setting rising sample again re-arms; position holds until a new edge.
// RULE16: Disabling a channel clears its status flags and keeps both positions.
// RULE17: Normal capture resolution is 55 microseconds on both edges.
// RULE18: High precision select gives channel two 2 us rising, 55 us falling.
// RULE19: High precision selection disables the encoder pulse output.
// RULE20: Single mode latches first edge until re-armed; continuous overwrites every edge.
`timescale 1ns/10ps
module touch_probe_position_latch
   import probe_latch_pkg::*;
#(
   parameter int COARSE_CYC = COARSE_RES_CYC,
   parameter int FINE_CYC = FINE_RES_CYC
) (
   input wire logic sys_clk,                      // System clock, 10 MHz
   input wire logic nrst,                         // Asynchronous reset, active low
   input wire logic probe_input_one,              // Probe pin of channel one
   input wire logic probe_input_two,              // Probe pin of channel two
   input wire logic [31:0] pos_feedback,          // Current position feedback
   input wire logic high_precision_select_param,  // Fine rising capture on channel two
   input wire obj_req_t obj_req,                  // Object access request
   output obj_rsp_t obj_rsp,                      // Object access answer
   output logic encoder_pulse_out_en              // Encoder pulse output allowed
);

   probe_ctrl_t ctrl_reg [0:1];
   logic [1:0] rise_st_reg;
   logic [1:0] fall_st_reg;
   logic [31:0] rise_pos_reg [0:1];
   logic [31:0] fall_pos_reg [0:1];
   logic hp_reg;
   logic [1:0] pin_in;
   logic [1:0] rise_evt;
   logic [1:0] fall_evt;
   logic [1:0] rise_hit;
   logic [1:0] fall_hit;
   logic [15:0] status_word;
   logic [31:0] rd_value;
   logic rd_mapped;
   logic ctrl_wr;

   // An edge counts only on an enabled channel using the probe input as source
   function automatic logic qualify(probe_ctrl_t c, logic sample, logic stored);
      // Single mode refuses a new edge while the earlier capture still stands
      return c.enable & ~c.src_zero_pt & sample & (c.continuous | ~stored);
   endfunction : qualify

   // Channel status byte from control and stored flags
   function automatic probe_stat_t pack_status(probe_ctrl_t c, logic rs, logic fs);
      probe_stat_t s;
      s = '0;
      s.enabled = c.enable;
      s.rise_stored = rs;
      s.fall_stored = fs;
      return s;
   endfunction : pack_status

   assign pin_in = {probe_input_two, probe_input_one};

   // One sampler per channel; only channel two may use the fine grid
   for (genvar c = 0; c < 2; c++) begin : g_smp
      probe_edge_sampler #(
         .COARSE_CYC(COARSE_CYC),
         .FINE_CYC(FINE_CYC)
      ) u_smp (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .pin(pin_in[c]),
         .fine_rise_sel((c == 1) ? hp_reg : 1'b0),
         .rise_evt(rise_evt[c]),
         .fall_evt(fall_evt[c])
      );
      assign rise_hit[c] = rise_evt[c] &
         qualify(ctrl_reg[c], ctrl_reg[c].sample_rise, rise_st_reg[c]); // RULE4 RULE2 RULE3
      assign fall_hit[c] = fall_evt[c] &
         qualify(ctrl_reg[c], ctrl_reg[c].sample_fall, fall_st_reg[c]); // RULE5 RULE2 RULE3
   end

   // Precision selection is a setting; registering it keeps the grid switch glitch free
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hp_reg <= 1'b0;
         encoder_pulse_out_en <= 1'b1;
      end else begin
         hp_reg <= high_precision_select_param; // RULE18
         encoder_pulse_out_en <= ~high_precision_select_param; // RULE19
      end
   end

   assign ctrl_wr = obj_req.req & obj_req.we & (obj_req.index == IDX_CONTROL);

   // Control word; reserved bits are dropped so they can never steer anything
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg[0] <= probe_ctrl_t'(CTRL_CH_RESET);
         ctrl_reg[1] <= probe_ctrl_t'(CTRL_CH_RESET);
      end else if (ctrl_wr) begin
         ctrl_reg[0] <= probe_ctrl_t'(obj_req.wdata[CH_BITS-1:0] & CTRL_DEFINED_MASK); // RULE6 RULE1
         ctrl_reg[1] <= probe_ctrl_t'(obj_req.wdata[CH2_BASE +: CH_BITS] &
                                      CTRL_DEFINED_MASK); // RULE6 RULE1
      end
   end

   // Stored flags; a capture wins, then a cleared sample bit or enable drops the flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rise_st_reg <= 2'h0;
         fall_st_reg <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (rise_hit[c]) begin
               rise_st_reg[c] <= 1'b1; // RULE8
            end else if (!ctrl_reg[c].enable || !ctrl_reg[c].sample_rise) begin
               rise_st_reg[c] <= 1'b0; // RULE14 RULE16 RULE15
            end
            if (fall_hit[c]) begin
               fall_st_reg[c] <= 1'b1; // RULE9
            end else if (!ctrl_reg[c].enable || !ctrl_reg[c].sample_fall) begin
               fall_st_reg[c] <= 1'b0; // RULE16
            end
         end
      end
   end

   // Latched positions; nothing but a qualifying edge touches them
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int c = 0; c < 2; c++) begin
            rise_pos_reg[c] <= POS_RESET; // RULE13
            fall_pos_reg[c] <= POS_RESET; // RULE13
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (rise_hit[c]) begin
               rise_pos_reg[c] <= pos_feedback; // RULE10 RULE12 RULE20
            end
            if (fall_hit[c]) begin
               fall_pos_reg[c] <= pos_feedback; // RULE11 RULE12 RULE20
            end
         end
      end
   end

   // Status word; enable bits mirror control directly
   assign status_word = {pack_status(ctrl_reg[1], rise_st_reg[1], fall_st_reg[1]),
                         pack_status(ctrl_reg[0], rise_st_reg[0], fall_st_reg[0])}; // RULE7

   // Object read selection
   always_comb begin
      rd_value = 32'h00000000;
      rd_mapped = 1'b1;
      case (obj_req.index)
         IDX_CONTROL: rd_value = {16'h0000, ctrl_reg[1], ctrl_reg[0]};
         IDX_STATUS: rd_value = {16'h0000, status_word};
         IDX_P1_RISE: rd_value = rise_pos_reg[0];
         IDX_P1_FALL: rd_value = fall_pos_reg[0];
         IDX_P2_RISE: rd_value = rise_pos_reg[1];
         IDX_P2_FALL: rd_value = fall_pos_reg[1];
         default: rd_mapped = 1'b0;
      endcase
   end

   // Answer one cycle after each request; writes to read-only objects are refused
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         obj_rsp <= '0;
      end else begin
         obj_rsp.ack <= obj_req.req;
         obj_rsp.err <= obj_req.req &
            (~rd_mapped | (obj_req.we & (obj_req.index != IDX_CONTROL))); // RULE13
         if (obj_req.req && !obj_req.we) begin
            obj_rsp.rdata <= rd_value;
         end
      end
   end

   // Checks on the channel logic
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   a_enable_follows_write: assert property (
      ctrl_wr |=> status_word[0] == $past(obj_req.wdata[0]) &&
                  status_word[CH2_BASE] == $past(obj_req.wdata[CH2_BASE])) // RULE1
      else $error("status enable does not follow control enable");

   a_status_mirrors_en: assert property (
      status_word[CH2_BASE] == ctrl_reg[1].enable && status_word[0] == ctrl_reg[0].enable) // RULE7
      else $error("status enable bit differs from control");

   a_ch1_rise_capture: assert property (
      rise_hit[0] |=> rise_pos_reg[0] == $past(pos_feedback) && rise_st_reg[0]) // RULE10
      else $error("channel one rising capture missing");

   a_ch1_fall_capture: assert property (
      fall_hit[0] |=> fall_pos_reg[0] == $past(pos_feedback) && fall_st_reg[0]) // RULE11
      else $error("channel one falling capture missing");

   a_ch2_rise_capture: assert property (
      rise_hit[1] |=> rise_pos_reg[1] == $past(pos_feedback) && status_word[9]) // RULE12
      else $error("channel two rising capture missing");

   a_rise_clear_keeps: assert property (
      !ctrl_reg[0].sample_rise ##1 !ctrl_reg[0].sample_rise |->
         !rise_st_reg[0] && $stable(rise_pos_reg[0])) // RULE14
      else $error("rising flag not cleared or position moved");

   a_disable_clears_all: assert property (
      !ctrl_reg[1].enable ##1 !ctrl_reg[1].enable |->
         status_word[10:8] == 3'h0 && $stable(rise_pos_reg[1]) &&
         $stable(fall_pos_reg[1])) // RULE16
      else $error("disabled channel kept flags or lost positions");

   a_single_holds_pos: assert property (
      rise_evt[0] && !ctrl_reg[0].continuous && rise_st_reg[0] |=>
         $stable(rise_pos_reg[0])) // RULE20
      else $error("single mode overwrote the first capture");

   a_cont_overwrites: assert property (
      rise_evt[0] && ctrl_reg[0].continuous && ctrl_reg[0].enable &&
      ctrl_reg[0].sample_rise && !ctrl_reg[0].src_zero_pt |=>
         rise_pos_reg[0] == $past(pos_feedback)) // RULE20
      else $error("continuous mode missed an edge");

   a_src_blocks_capture: assert property (
      ctrl_reg[0].src_zero_pt |-> !rise_hit[0] && !fall_hit[0]) // RULE3
      else $error("capture taken from the unsupported source");

   a_hp_pulse_off: assert property (
      high_precision_select_param |=> !encoder_pulse_out_en ##0 hp_reg) // RULE19
      else $error("encoder pulse output left on in high precision");

   c_ch1_both_edges: cover property (rise_hit[0] ##[1:1000] fall_hit[0]);
   c_ch2_fine_rise: cover property (hp_reg && rise_hit[1]);
   c_rearm_capture: cover property (!ctrl_reg[0].sample_rise ##1
                                    ctrl_reg[0].sample_rise ##[1:1000] rise_hit[0]);
   c_obj_error: cover property (obj_rsp.ack && obj_rsp.err);

endmodule : touch_probe_position_latch

// ==== bench/probe_sensor_model.sv ====
// Behavioural model of the probe sensors and the position feedback source
`timescale 1ns/10ps
module probe_sensor_model (
   input wire logic sys_clk,          // System clock
   input wire logic nrst,             // Asynchronous reset, active low
   input wire logic level_one_req,    // Wanted level of probe pin one
   input wire logic level_two_req,    // Wanted level of probe pin two
   input wire logic [31:0] pos_req,   // Wanted position feedback
   output logic probe_input_one,      // Probe pin one
   output logic probe_input_two,      // Probe pin two
   output logic [31:0] pos_feedback   // Position feedback to the latch
);
   // Pins and position change just after a rising edge, as a real sensor path would
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         probe_input_one <= 1'b0;
         probe_input_two <= 1'b0;
         pos_feedback <= 32'h00000000;
      end else begin
         probe_input_one <= level_one_req;
         probe_input_two <= level_two_req;
         pos_feedback <= pos_req;
      end
   end
endmodule : probe_sensor_model

// ==== bench/touch_probe_position_latch_tb_top.sv ====
// Self-checking testbench of the touch probe position latch
`timescale 1ns/10ps
module touch_probe_position_latch_tb_top;
   import probe_latch_pkg::*;
   // Small tick periods keep the run short; waits below derive from them
   localparam int COARSE = 10;
   localparam int FINE = 3;
   localparam int CAP_WAIT = COARSE + 6;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic lvl_one = 1'b0;
   logic lvl_two = 1'b0;
   logic hp_sel = 1'b0;
   logic [31:0] pos_set = 32'h00000000;
   logic pin_one;
   logic pin_two;
   logic [31:0] pos_fb;
   logic enc_en;
   obj_req_t obj_req = '0;
   obj_rsp_t obj_rsp;
   int miscompares = 0;
   int comparisons = 0;

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   probe_sensor_model sensor (.sys_clk(sys_clk), .nrst(nrst), .level_one_req(lvl_one),
      .level_two_req(lvl_two), .pos_req(pos_set), .probe_input_one(pin_one),
      .probe_input_two(pin_two), .pos_feedback(pos_fb));

   touch_probe_position_latch #(.COARSE_CYC(COARSE), .FINE_CYC(FINE)) uut (
      .sys_clk(sys_clk), .nrst(nrst), .probe_input_one(pin_one), .probe_input_two(pin_two),
      .pos_feedback(pos_fb), .high_precision_select_param(hp_sel), .obj_req(obj_req),
      .obj_rsp(obj_rsp), .encoder_pulse_out_en(enc_en));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : idle

   // One object access; the answer stands for exactly the cycle after the taking edge
   task automatic access(input logic we, input logic [15:0] idx, input logic [31:0] wd,
                         input logic exp_err, output logic [31:0] rd);
      @(negedge sys_clk);
      obj_req = '{req: 1'b1, we: we, index: idx, wdata: wd};
      @(negedge sys_clk);
      obj_req = '0;
      check("ack", {31'h0, obj_rsp.ack}, 32'h1);
      check("err", {31'h0, obj_rsp.err}, {31'h0, exp_err});
      rd = obj_rsp.rdata;
   endtask : access

   task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] v;
      access(1'b0, idx, 32'h0, 1'b0, v);
      check($sformatf("object %h", idx), v, exp);
   endtask : rd

   task automatic wr(input logic [15:0] wd);
      logic [31:0] v;
      access(1'b1, IDX_CONTROL, {16'h0, wd}, 1'b0, v);
      // Stored flags follow the control register one cycle late, so let them settle
      idle(1);
   endtask : wr

   // Moves a pin with a new position present and waits out one sampling period
   task automatic edge_one(input logic lvl, input logic [31:0] pos);
      pos_set = pos;
      lvl_one = lvl;
      idle(CAP_WAIT);
   endtask : edge_one

   task automatic reset_values;
      logic [31:0] v;
      rd(IDX_STATUS, 32'h0);
      rd(IDX_P1_RISE, 32'h0);
      rd(IDX_P1_FALL, 32'h0);
      rd(IDX_P2_RISE, 32'h0);
      rd(IDX_P2_FALL, 32'h0);
      check("encoder enable", {31'h0, enc_en}, 32'h1);
      access(1'b0, 16'h60BE, 32'h0, 1'b1, v);
      access(1'b1, IDX_P1_RISE, 32'h12345678, 1'b1, v);
      rd(IDX_P1_RISE, 32'h0);
   endtask : reset_values

   task automatic ch1_capture;
      wr(16'h0031);
      rd(IDX_CONTROL, 32'h0031);
      rd(IDX_STATUS, 32'h0001);
      edge_one(1'b1, 32'h11111111);
      rd(IDX_STATUS, 32'h0003);
      rd(IDX_P1_RISE, 32'h11111111);
      edge_one(1'b0, 32'h22222222);
      rd(IDX_STATUS, 32'h0007);
      rd(IDX_P1_FALL, 32'h22222222);
   endtask : ch1_capture

   task automatic rearm_and_modes;
      wr(16'h0021);
      rd(IDX_STATUS, 32'h0005);
      rd(IDX_P1_RISE, 32'h11111111);
      wr(16'h0031);
      rd(IDX_P1_RISE, 32'h11111111);
      edge_one(1'b1, 32'h33333333);
      rd(IDX_P1_RISE, 32'h33333333);
      // Single mode refuses further edges while the flags stand
      edge_one(1'b0, 32'h44444444);
      rd(IDX_P1_FALL, 32'h22222222);
      edge_one(1'b1, 32'h44444444);
      rd(IDX_P1_RISE, 32'h33333333);
      wr(16'h0033);
      edge_one(1'b0, 32'h44444444);
      rd(IDX_P1_FALL, 32'h44444444);
      edge_one(1'b1, 32'h55555555);
      rd(IDX_P1_RISE, 32'h55555555);
   endtask : rearm_and_modes

   task automatic disable_and_source;
      wr(16'h0000);
      rd(IDX_STATUS, 32'h0000);
      rd(IDX_P1_RISE, 32'h55555555);
      rd(IDX_P1_FALL, 32'h44444444);
      edge_one(1'b0, 32'h66666666);
      rd(IDX_P1_FALL, 32'h44444444);
      wr(16'h0015);
      edge_one(1'b1, 32'h66666666);
      rd(IDX_STATUS, 32'h0001);
      rd(IDX_P1_RISE, 32'h55555555);
      wr(16'h0000);
   endtask : disable_and_source

   task automatic ch2_precision;
      hp_sel = 1'b1;
      idle(2);
      check("encoder enable", {31'h0, enc_en}, 32'h0);
      wr(16'h3100);
      rd(IDX_STATUS, 32'h0100);
      pos_set = 32'h77777777;
      lvl_two = 1'b1;
      idle(FINE + 5);
      rd(IDX_P2_RISE, 32'h77777777);
      pos_set = 32'h88888888;
      lvl_two = 1'b0;
      idle(CAP_WAIT);
      rd(IDX_STATUS, 32'h0700);
      rd(IDX_P2_FALL, 32'h88888888);
      rd(IDX_P1_RISE, 32'h55555555);
      hp_sel = 1'b0;
      idle(2);
      check("encoder enable", {31'h0, enc_en}, 32'h1);
   endtask : ch2_precision

   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize

   // Watchdog cuts a hung run short
   initial begin
      #(20000 * 100);
      miscompares++;
      summarize();
   end

   initial begin
      repeat (2) @(negedge sys_clk);
      nrst = 1'b1;
      reset_values();
      ch1_capture();
      rearm_and_modes();
      disable_and_source();
      ch2_precision();
      summarize();
   end
endmodule : touch_probe_position_latch_tb_top
